// ==== tpc_block_timer.sv ====
module tpc_block_timer #(
	parameter int CNT_W = 16
) (
	input wire logic clock, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire tpc_pkg::tpc_mode_type mode, // Block counter mode
	input wire logic [3:0] slot_level, // Synchronised levels of the block pins
	input wire logic sync_level, // Synchronised external sync level
	input wire logic [CNT_W-1:0] limit, // Rollover value
	input wire logic [CNT_W-1:0] duty, // PWM compare value
	output logic [CNT_W-1:0] count_q, // Counter value
	output logic rollover_q, // Pulse on rollover
	output logic pwm_q, // PWM level
	output logic [CNT_W-1:0] capture_q // Count captured at pin 2 edge
);
	import tpc_pkg::*;

	logic [3:0] slot_prev_q;
	logic sync_prev_q;
	logic run_q;
	logic [3:0] rise;
	logic sync_rise;
	logic tick;
	logic down;

	assign rise = slot_level & ~slot_prev_q;
	assign sync_rise = sync_level & ~sync_prev_q;

	// Edge history
	always_ff @(posedge clock) begin
		if (srst) begin
			slot_prev_q <= 4'h0;
			sync_prev_q <= 1'b0;
		end else if (ce) begin
			slot_prev_q <= slot_level;
			sync_prev_q <= sync_level;
		end
	end

	// Gate for the begin/end modes
	always_ff @(posedge clock) begin
		if (srst) begin
			run_q <= 1'b0;
		end else if (ce) begin
			if (mode == MD_UNTIL_END) begin
				run_q <= ~rise[1] & (run_q | ~slot_prev_q[1]);
			end else if (mode == MD_BEGIN_END) begin
				run_q <= rise[0] | (run_q & ~rise[1]);
			end else begin
				run_q <= 1'b0;
			end
		end
	end

	// Count step per mode
	always_comb begin
		tick = 1'b0;
		down = 1'b0;
		case (mode)
			MD_UP: tick = rise[0];
			MD_MATCH: tick = rise[0] && (count_q != limit);
			MD_UPDN: begin
				tick = rise[0];
				down = slot_level[1];
			end
			MD_FREE: tick = 1'b1;
			MD_UNTIL_END, MD_BEGIN_END: tick = run_q;
			MD_WHILE_BEGIN: tick = slot_level[0];
			default: tick = 1'b0;
		endcase
	end

	// Counter with rollover at the limit and sync clear
	always_ff @(posedge clock) begin
		if (srst) begin
			count_q <= COUNT_RST;
			rollover_q <= 1'b0;
		end else if (ce) begin
			rollover_q <= 1'b0;
			if (sync_rise) begin
				count_q <= COUNT_RST;
			end else if (tick && down) begin
				count_q <= (count_q == COUNT_RST) ? limit : count_q - CNT_W'(1);
			end else if (tick && count_q >= limit) begin
				count_q <= COUNT_RST;
				rollover_q <= 1'b1;
			end else if (tick) begin
				count_q <= count_q + CNT_W'(1);
			end
		end
	end

	// PWM from the shared count, capture of the same count
	always_ff @(posedge clock) begin
		if (srst) begin
			pwm_q <= 1'b0;
			capture_q <= COUNT_RST;
		end else if (ce) begin
			pwm_q <= (count_q < duty);
			if (rise[2]) begin
				capture_q <= count_q;
			end
		end
	end

endmodule : tpc_block_timer

// ==== tpc_conflict_checker.sv ====
module tpc_conflict_checker (
	input wire logic clock, // System clock, 250 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic req_valid, // Function request strobe
	input wire logic [tpc_pkg::PIN_W-1:0] req_pin, // Board pin index
	input wire tpc_pkg::tpc_func_type req_func, // Requested function
	input wire tpc_pkg::tpc_mode_type req_mode, // Block mode it needs
	input wire logic [tpc_pkg::NUM_INPUTS-1:0] pin_in, // Raw digital inputs
	input wire logic [tpc_pkg::NUM_OUTPUTS-1:0] out_level, // Levels for plain outputs
	input wire logic [tpc_pkg::CNT_W-1:0] limit [tpc_pkg::NUM_BLOCKS], // Rollover values
	input wire logic [tpc_pkg::CNT_W-1:0] duty [tpc_pkg::NUM_BLOCKS], // PWM compare values
	output logic rsp_valid_q, // Answer pulse
	output logic rsp_accept_q, // Request taken
	output logic rsp_unsupported_q, // Refused for pin or mode reasons
	output logic [tpc_pkg::CODE_W-1:0] rsp_code_q, // Mode conflict code
	output logic [tpc_pkg::NUM_OUTPUTS-1:0] pin_out_q, // Digital outputs
	output logic [tpc_pkg::CNT_W-1:0] count_q [tpc_pkg::NUM_BLOCKS], // Block counters
	output logic [tpc_pkg::NUM_BLOCKS-1:0] rollover_q, // Rollover pulses
	output logic [tpc_pkg::CNT_W-1:0] capture_q [tpc_pkg::NUM_BLOCKS] // Captured counts
);
	import tpc_pkg::*;

	tpc_func_type func_q [NUM_PINS];
	tpc_mode_type mode_q [NUM_PINS];
	tpc_mode_type blk_mode_q [NUM_BLOCKS];
	logic [3:0] slot_level_q [NUM_BLOCKS];
	logic [NUM_BLOCKS-1:0] sync_level_q;
	logic [NUM_BLOCKS-1:0] pwm_q;
	logic [NUM_INPUTS-1:0] pin_meta_q;
	logic [NUM_INPUTS-1:0] pin_sync_q;

	logic pin_ok;
	logic [PIN_W-1:0] req_idx;
	logic dir_ok;
	logic quad_ok;
	tpc_class_type req_class;
	logic [MASK_W-1:0] mask_d;
	logic accept_d;
	logic unsupported_d;
	tpc_mode_type blk_mode_d [NUM_BLOCKS];
	logic [3:0] slot_level_d [NUM_BLOCKS];
	logic [NUM_BLOCKS-1:0] sync_level_d;
	logic [NUM_OUTPUTS-1:0] pin_out_d;

	// Two-flop synchroniser on the raw input pins
	always_ff @(posedge clock) begin
		if (srst) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else if (ce) begin
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Request legality: pin range, direction and quadrature pins
	always_comb begin
		pin_ok = (req_pin <= LAST_PIN_IDX);
		req_idx = pin_ok ? req_pin : DIGITAL_INPUT_0_IDX;
		req_class = tpc_class_of(req_func, req_mode);
		if (req_func == FN_DIG_OUT || req_func == FN_PWM) begin
			dir_ok = (req_idx >= DIGITAL_OUTPUT_0_IDX);
		end else if (req_func == FN_NONE) begin
			dir_ok = 1'b1;
		end else begin
			dir_ok = (req_idx < DIGITAL_OUTPUT_0_IDX);
		end
		quad_ok = (req_func != FN_QUAD) || (req_idx <= DIGITAL_INPUT_5_IDX);
	end

	// Conflict mask over the other pins of the same block
	always_comb begin
		mask_d = '0;
		for (int p = 0; p < NUM_PINS; p++) begin
			if (PIN_BLOCK[p] == PIN_BLOCK[req_idx] && p != int'(req_idx)) begin
				if (tpc_clash(req_class, req_mode, tpc_class_of(func_q[p], mode_q[p]), mode_q[p])) begin
					mask_d[PIN_SLOT[p]] = 1'b1;
				end
			end
		end
		if (req_func == FN_NONE) begin
			mask_d = '0;
		end
	end

	// Accept only a legal request without clashes
	always_comb begin
		unsupported_d = !pin_ok || !dir_ok || !quad_ok || (req_class == CL_NONE);
		accept_d = !unsupported_d && (mask_d == '0);
	end

	// Answer one cycle after the request
	always_ff @(posedge clock) begin
		if (srst) begin
			rsp_valid_q <= 1'b0;
			rsp_accept_q <= 1'b0;
			rsp_unsupported_q <= 1'b0;
			rsp_code_q <= 8'h00;
		end else if (ce) begin
			rsp_valid_q <= req_valid;
			if (req_valid) begin
				rsp_accept_q <= accept_d;
				rsp_unsupported_q <= unsupported_d;
				rsp_code_q <= unsupported_d ? 8'h00 : {4'h0, mask_d};
			end
		end
	end

	// Pin function table, written on an accepted request
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int p = 0; p < NUM_PINS; p++) begin
				func_q[p] <= FN_NONE;
				mode_q[p] <= BLOCK_MODE_RST;
			end
		end else if (ce) begin
			if (req_valid && accept_d) begin
				func_q[req_idx] <= req_func;
				mode_q[req_idx] <= req_mode;
			end
		end
	end

	// Block mode and block pin levels from the table and the pin map
	always_comb begin
		for (int b = 0; b < NUM_BLOCKS; b++) begin
			blk_mode_d[b] = BLOCK_MODE_RST;
			slot_level_d[b] = 4'h0;
		end
		sync_level_d = '0;
		for (int p = NUM_PINS - 1; p >= 0; p--) begin
			if (tpc_class_of(func_q[p], mode_q[p]) != CL_ANY) begin
				blk_mode_d[PIN_BLOCK[p]] = mode_q[p];
			end
		end
		for (int p = 0; p < NUM_INPUTS; p++) begin
			slot_level_d[PIN_BLOCK[p]][PIN_SLOT[p]] = slot_level_d[PIN_BLOCK[p]][PIN_SLOT[p]] | pin_sync_q[p];
			if (func_q[p] == FN_EXT_SYNC) begin
				sync_level_d[PIN_BLOCK[p]] = sync_level_d[PIN_BLOCK[p]] | pin_sync_q[p];
			end
		end
	end

	// Register block controls feeding the timers
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int b = 0; b < NUM_BLOCKS; b++) begin
				blk_mode_q[b] <= BLOCK_MODE_RST;
				slot_level_q[b] <= 4'h0;
			end
			sync_level_q <= '0;
		end else if (ce) begin
			blk_mode_q <= blk_mode_d;
			slot_level_q <= slot_level_d;
			sync_level_q <= sync_level_d;
		end
	end

	// Outputs take PWM from their own block when so assigned
	always_comb begin
		for (int k = 0; k < NUM_OUTPUTS; k++) begin
			if (func_q[NUM_INPUTS + k] == FN_PWM) begin
				pin_out_d[k] = pwm_q[PIN_BLOCK[NUM_INPUTS + k]];
			end else if (func_q[NUM_INPUTS + k] == FN_DIG_OUT) begin
				pin_out_d[k] = out_level[k];
			end else begin
				pin_out_d[k] = 1'b0;
			end
		end
	end

	// Output pin register
	always_ff @(posedge clock) begin
		if (srst) begin
			pin_out_q <= '0;
		end else if (ce) begin
			pin_out_q <= pin_out_d;
		end
	end

	// One counter/timer per block
	for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_block
		tpc_block_timer #(
			.CNT_W(CNT_W)
		) u_timer (
			.clock(clock),
			.srst(srst),
			.ce(ce),
			.mode(blk_mode_q[b]),
			.slot_level(slot_level_q[b]),
			.sync_level(sync_level_q[b]),
			.limit(limit[b]),
			.duty(duty[b]),
			.count_q(count_q[b]),
			.rollover_q(rollover_q[b]),
			.pwm_q(pwm_q[b]),
			.capture_q(capture_q[b])
		);
	end

endmodule : tpc_conflict_checker

// ==== tpc_conflict_checker_bench.sv ====
module tpc_conflict_checker_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import tpc_pkg::*;

	localparam logic [9:0] ACC = 10'h200;
	localparam logic [9:0] UNS = 10'h100;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic req_valid = 1'b0;
	logic [PIN_W-1:0] req_pin = 5'h00;
	tpc_func_type req_func = FN_NONE;
	tpc_mode_type req_mode = MD_UP;
	logic [NUM_INPUTS-1:0] pin_in = 12'h000;
	logic [NUM_OUTPUTS-1:0] out_level = 8'h00;
	logic [CNT_W-1:0] limit [NUM_BLOCKS] = '{default: 16'h0040};
	logic [CNT_W-1:0] duty [NUM_BLOCKS] = '{default: 16'h0010};
	logic rsp_valid_q, rsp_accept_q, rsp_unsupported_q;
	logic [CODE_W-1:0] rsp_code_q;
	logic [31:0] seed = 32'h61a9fb6d;
	logic [9:0] exp_q [$];
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	logic out_pend = 1'b0;
	logic out_tab = 1'b0;
	logic [CNT_W-1:0] ref_cnt = 16'h0000;
	logic ref_roll = 1'b0;
	logic [NUM_OUTPUTS-2:0] ref_out = 7'h00;
	logic [CNT_W:0] tmr_q [$];
	logic [NUM_OUTPUTS-2:0] pin_q [$];
	logic [NUM_OUTPUTS-1:0] pin_out_q;
	logic [CNT_W-1:0] count_q [NUM_BLOCKS];
	logic [NUM_BLOCKS-1:0] rollover_q;

	tpc_conflict_checker dut (.clock(clock), .srst(srst), .ce(ce), .req_valid(req_valid), .req_pin(req_pin),
		.req_func(req_func), .req_mode(req_mode), .pin_in(pin_in), .out_level(out_level), .limit(limit),
		.duty(duty), .rsp_valid_q(rsp_valid_q), .rsp_accept_q(rsp_accept_q),
		.rsp_unsupported_q(rsp_unsupported_q), .rsp_code_q(rsp_code_q), .pin_out_q(pin_out_q), .count_q(count_q),
		.rollover_q(rollover_q), .capture_q());

	// Clock generation
	initial begin
		forever #2 clock = ~clock;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	// Random pin levels and timer settings
	always @(posedge clock) begin
		#1;
		seed = lfsr_next(seed);
		pin_in <= seed[11:0];
		out_level <= seed[19:12];
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			limit[i] <= {8'h00, seed[31:24]};
			duty[i] <= {8'h00, seed[27:20]};
		end
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	task automatic check_rsp(input logic [9:0] e, input logic [9:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch response expected %h seen %h", e, g);
		end
	endtask : check_rsp

	task automatic check_count(input logic [CNT_W:0] e, input logic [CNT_W:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch block timer expected %h seen %h", e, g);
		end
	endtask : check_count

	task automatic check_pins(input logic [NUM_OUTPUTS-2:0] e, input logic [NUM_OUTPUTS-2:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch output pins expected %h seen %h", e, g);
		end
	endtask : check_pins

	// Issue one request and note its answer
	task automatic req(input logic [4:0] p, input tpc_func_type f, input tpc_mode_type m, input logic [9:0] e);
		req_valid = 1'b1;
		req_pin = p;
		req_func = f;
		req_mode = m;
		exp_q.push_back(e);
		@(posedge clock);
		#1;
	endtask : req

	// Reference for the free-running block 4 timer and output pins 7 to 1
	// Block 4 has no input pins and no request touches it, so it stays in free-running mode
	always @(posedge clock) begin
		if (srst) begin
			ref_cnt = COUNT_RST;
			ref_roll = 1'b0;
			ref_out = 7'h00;
			out_tab = 1'b0;
		end else if (ce) begin
			ref_roll = (ref_cnt >= limit[4]);
			ref_cnt = ref_roll ? COUNT_RST : ref_cnt + 16'h0001;
			ref_out = {4'h0, out_tab & out_level[3], 2'h0};
			out_tab = out_pend;
		end
		tmr_q.push_back({ref_roll, ref_cnt});
		pin_q.push_back(ref_out);
	end

	// Answer, block 4 timer and output pin watcher
	always @(negedge clock) begin
		if (rsp_valid_q === 1'b1) begin
			if (exp_q.size() == 0) begin
				check_rsp(10'h3FF, {rsp_accept_q, rsp_unsupported_q, rsp_code_q});
			end else begin
				check_rsp(exp_q.pop_front(), {rsp_accept_q, rsp_unsupported_q, rsp_code_q});
			end
		end
		if (tmr_q.size() != 0) begin
			check_count(tmr_q.pop_front(), {rollover_q[4], count_q[4]});
		end
		if (pin_q.size() != 0) begin
			check_pins(pin_q.pop_front(), pin_out_q[NUM_OUTPUTS-1:1]);
		end
	end

	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles > 2000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		repeat (3) @(posedge clock);
		#1;
		srst = 1'b0;
		req(5'h00, FN_EVT_CAP, MD_FREE, ACC);
		req(5'h01, FN_EVT_CAP, MD_FREE, ACC);
		req(5'h02, FN_EVT_CNT, MD_UP, 10'h003);
		req(5'h02, FN_QUAD, MD_UPDN, 10'h003);
		req(5'h02, FN_EVT_CAP, MD_FREE, ACC);
		req(5'h03, FN_EVT_CNT, MD_UP, ACC);
		req(5'h04, FN_EVT_CAP, MD_BEGIN_END, 10'h001);
		req(5'h0C, FN_PWM, MD_FREE, ACC);
		req(5'h06, FN_EVT_CAP, MD_FREE, ACC);
		req(5'h07, FN_EVT_CNT, MD_MATCH, 10'h005);
		req(5'h07, FN_EXT_SYNC, MD_UP, ACC);
		req(5'h0D, FN_PWM, MD_UP, UNS);
		req(5'h06, FN_QUAD, MD_UPDN, UNS);
		req(5'h0C, FN_DIG_IN, MD_FREE, UNS);
		req(5'h14, FN_DIG_IN, MD_FREE, UNS);
		req(5'h0A, FN_EVT_CNT, MD_UP, ACC);
		req(5'h0A, FN_EVT_CAP, MD_WHILE_BEGIN, ACC);
		req(5'h0B, FN_QUAD, MD_UPDN, UNS);
		req(5'h08, FN_EVT_CNT, MD_UP, ACC);
		req(5'h13, FN_PWM, MD_FREE, 10'h001);
		out_pend = 1'b1;
		req(5'h0F, FN_DIG_OUT, MD_UPDN, ACC);
		for (int m = 0; m < 7; m++) begin
			req(5'h05, FN_EXT_IRQ, tpc_mode_type'(m), ACC);
		end
		req(5'h00, FN_NONE, MD_FREE, ACC);
		req(5'h02, FN_EVT_CNT, MD_UP, 10'h002);
		// Request while the clock enable is low is ignored
		req_valid = 1'b0;
		@(posedge clock);
		#1;
		ce = 1'b0;
		req_valid = 1'b1;
		@(posedge clock);
		#1;
		ce = 1'b1;
		req_valid = 1'b0;
		// Mid-run reset empties the pin table, so the earlier clash is gone
		srst = 1'b1;
		out_pend = 1'b0;
		@(posedge clock);
		#1;
		srst = 1'b0;
		req(5'h02, FN_EVT_CNT, MD_UP, ACC);
		req_valid = 1'b0;
		repeat (30) @(posedge clock);
		if (exp_q.size() != 0) begin
			mismatches++;
			$display("mismatch pending expected 0 seen %0d", exp_q.size());
		end
		complete_run();
	end
endmodule : tpc_conflict_checker_bench

// ==== tpc_monitor.sv ====
module tpc_monitor (
	input wire logic clock, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic req_valid, // Request strobe
	input wire logic [tpc_pkg::PIN_W-1:0] req_pin, // Board pin index
	input wire tpc_pkg::tpc_func_type req_func, // Requested function
	input wire logic rsp_valid_q, // Answer pulse
	input wire logic rsp_accept_q, // Request taken
	input wire logic rsp_unsupported_q, // Refused for pin or mode
	input wire logic [tpc_pkg::CODE_W-1:0] rsp_code_q // Conflict code
);
	import tpc_pkg::*;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// Response timing and content relations
	property p_upper_zero; rsp_code_q[7:4] == 4'h0; endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("conflict code upper nibble set");
	property p_answer; ce && req_valid |=> rsp_valid_q; endproperty
	a_answer: assert property (p_answer) else $error("request not answered next cycle");
	property p_no_extra; ce && !req_valid |=> !rsp_valid_q; endproperty
	a_no_extra: assert property (p_no_extra) else $error("answer without request");
	property p_accept_zero; rsp_accept_q |-> rsp_code_q == 8'h00 && !rsp_unsupported_q; endproperty
	a_accept_zero: assert property (p_accept_zero) else $error("accepted answer carries a code");
	property p_unsup_zero; rsp_unsupported_q |-> rsp_code_q == 8'h00 && !rsp_accept_q; endproperty
	a_unsup_zero: assert property (p_unsup_zero) else $error("unsupported answer carries a code");
	property p_reason; rsp_valid_q && !rsp_accept_q |-> rsp_unsupported_q || rsp_code_q != 8'h00; endproperty
	a_reason: assert property (p_reason) else $error("refusal without a reason");
	property p_any_ok;
		ce && req_valid && ((req_func inside {FN_DIG_IN, FN_EXT_IRQ, FN_EXT_SYNC} && req_pin < 5'h0C) ||
			(req_func == FN_DIG_OUT && req_pin >= 5'h0C && req_pin <= 5'h13)) |=> rsp_accept_q;
	endproperty
	a_any_ok: assert property (p_any_ok) else $error("plain function refused");
	property p_quad_pin; ce && req_valid && req_func == FN_QUAD && req_pin > 5'h05 |=> rsp_unsupported_q; endproperty
	a_quad_pin: assert property (p_quad_pin) else $error("quadrature accepted on high pin");
	property p_held; ce && !req_valid |=> $stable(rsp_accept_q) && $stable(rsp_code_q); endproperty
	a_held: assert property (p_held) else $error("answer fields changed without request");

	// Main outcomes
	c_accept: cover property (rsp_valid_q && rsp_accept_q);
	c_conflict: cover property (rsp_valid_q && rsp_code_q != 8'h00);
	c_unsup: cover property (rsp_valid_q && rsp_unsupported_q);
endmodule : tpc_monitor

bind tpc_conflict_checker tpc_monitor u_monitor (.clock(clock), .srst(srst), .ce(ce), .req_valid(req_valid),
	.req_pin(req_pin), .req_func(req_func), .rsp_valid_q(rsp_valid_q), .rsp_accept_q(rsp_accept_q),
	.rsp_unsupported_q(rsp_unsupported_q), .rsp_code_q(rsp_code_q));

// ==== tpc_pkg.sv ====
package tpc_pkg;

	// Bank geometry
	localparam int NUM_BLOCKS = 8;
	localparam int NUM_SLOTS = 4;
	localparam int NUM_INPUTS = 12;
	localparam int NUM_OUTPUTS = 8;
	localparam int NUM_PINS = NUM_INPUTS + NUM_OUTPUTS;
	localparam int PIN_W = 5;
	localparam int CNT_W = 16;
	localparam int CODE_W = 8;
	localparam int MASK_W = 4;

	// Board pin indices: inputs first, then outputs
	localparam logic [PIN_W-1:0] DIGITAL_INPUT_0_IDX = 5'h00;
	localparam logic [PIN_W-1:0] DIGITAL_INPUT_1_IDX = 5'h01;
	localparam logic [PIN_W-1:0] DIGITAL_INPUT_2_IDX = 5'h02;
	localparam logic [PIN_W-1:0] DIGITAL_INPUT_5_IDX = 5'h05;
	localparam logic [PIN_W-1:0] DIGITAL_INPUT_6_IDX = 5'h06;
	localparam logic [PIN_W-1:0] DIGITAL_INPUT_9_IDX = 5'h09;
	localparam logic [PIN_W-1:0] DIGITAL_INPUT_10_IDX = 5'h0A;
	localparam logic [PIN_W-1:0] DIGITAL_INPUT_11_IDX = 5'h0B;
	localparam logic [PIN_W-1:0] DIGITAL_OUTPUT_0_IDX = 5'h0C;
	localparam logic [PIN_W-1:0] DIGITAL_OUTPUT_3_IDX = 5'h0F;
	localparam logic [PIN_W-1:0] LAST_PIN_IDX = 5'h13;

	// Block owning each board pin
	localparam logic [2:0] PIN_BLOCK [NUM_PINS] = '{
		3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h6, 3'h7,
		3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h3};

	// Position of each board pin inside its block
	localparam logic [1:0] PIN_SLOT [NUM_PINS] = '{
		2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0,
		2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3};

	typedef enum logic [3:0] {
		FN_NONE = 4'h0,
		FN_DIG_IN = 4'h1,
		FN_DIG_OUT = 4'h2,
		FN_EVT_CNT = 4'h3,
		FN_EVT_CAP = 4'h4,
		FN_QUAD = 4'h5,
		FN_EXT_IRQ = 4'h6,
		FN_EXT_SYNC = 4'h7,
		FN_PWM = 4'h8
	} tpc_func_type;

	typedef enum logic [2:0] {
		MD_UP = 3'h0,
		MD_MATCH = 3'h1,
		MD_UPDN = 3'h2,
		MD_FREE = 3'h3,
		MD_UNTIL_END = 3'h4,
		MD_BEGIN_END = 3'h5,
		MD_WHILE_BEGIN = 3'h6
	} tpc_mode_type;

	typedef enum logic [1:0] {
		CL_ANY = 2'h0,
		CL_EXCL = 2'h1,
		CL_SHARED = 2'h2,
		CL_NONE = 2'h3
	} tpc_class_type;

	// Reset values
	localparam tpc_mode_type BLOCK_MODE_RST = MD_FREE;
	localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;

	// Sharing class of a function in a given block mode
	function automatic tpc_class_type tpc_class_of(input tpc_func_type f, input tpc_mode_type m);
		tpc_class_type c;
		c = CL_NONE;
		case (f)
			FN_NONE, FN_DIG_IN, FN_DIG_OUT, FN_EXT_IRQ, FN_EXT_SYNC: c = CL_ANY;
			FN_EVT_CNT: c = (m <= MD_UPDN) ? CL_EXCL : CL_NONE;
			FN_EVT_CAP: c = (m == MD_FREE) ? CL_SHARED : ((m >= MD_UNTIL_END && m <= MD_WHILE_BEGIN) ? CL_EXCL : CL_NONE);
			FN_QUAD: c = (m == MD_UPDN) ? CL_EXCL : CL_NONE;
			FN_PWM: c = (m == MD_FREE) ? CL_SHARED : CL_NONE;
			default: c = CL_NONE;
		endcase
		return c;
	endfunction : tpc_class_of

	// Two functions on one block clash
	function automatic logic tpc_clash(input tpc_class_type ca, input tpc_mode_type ma,
			input tpc_class_type cb, input tpc_mode_type mb);
		logic r;
		r = 1'b0;
		if (ca == CL_ANY || cb == CL_ANY) begin
			r = 1'b0;
		end else if (ma != mb) begin
			r = 1'b1;
		end else begin
			r = (ca == CL_EXCL) || (cb == CL_EXCL);
		end
		return r;
	endfunction : tpc_clash

endpackage : tpc_pkg
